// *** include/uep_pkg.sv ***
// ==========================================
// uart receive control package
package uep_pkg;

	// ==========================================
	// register byte addresses
	localparam logic [3:0] ADDR_ACS  = 4'h0;
	localparam logic [3:0] ADDR_RXD  = 4'h4;
	localparam logic [3:0] ADDR_IST  = 4'h8;
	localparam logic [3:0] ADDR_IMK  = 4'hC;

	// ==========================================
	// control and status bit positions
	localparam int BIT_ERR  = 7;
	localparam int BIT_SEM  = 6;
	localparam int BIT_REN  = 5;
	localparam int BIT_EVEN = 4;
	localparam int BIT_PEN  = 3;
	localparam int BIT_W8   = 2;
	localparam logic [7:0] ACS_RESET = 8'h00;

	// ==========================================
	// interrupt status bit positions
	localparam int IRQ_RX  = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// ==========================================
	// oversampling counts, baud tick is 16x
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_HALF = 4'h7;
	localparam logic [2:0] BITS_W8   = 3'h7;
	localparam logic [2:0] BITS_W7   = 3'h6;

	// ==========================================
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// receiver states
	typedef enum logic [2:0] {
		UEP_IDLE,
		UEP_START,
		UEP_DATA,
		UEP_PAR,
		UEP_STOP
	} uep_state_t;

endpackage

// *** logic/uep_rx_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// - any receive error sets bit 7 flag
// - parity bit mismatch flags an error
// - low stop bit flags framing error
// - transfer over unread data flags overrun
// - flag clears only on writing one
// - bit 5 enables receiver, interrupt, pin
// - bit 4 set selects even parity
// - bit 4 clear selects odd parity
// - whole register resets to zero
// - each character transfer raises receive interrupt
module uep_rx_ctrl (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// serial side
	input  wire logic        baud_tick16,
	input  wire logic        serial_receive_pin,
	output logic             receiver_pin_select,
	output logic             receive_interrupt_request,
	// interrupt
	output logic             irq
);
	import uep_pkg::*;

	// ==========================================
	// register state
	logic             rx_error_flag;
	logic             software_semaphore_bit;
	logic             receiver_enable_bit;
	logic             parity_sense_select;
	logic [3:0]       acs_low;
	logic [7:0]       rx_data;
	logic             unread;
	logic [1:0]       irq_status;
	logic [1:0]       irq_mask;

	// ==========================================
	// write channel state
	logic             aw_hold;
	logic             w_hold;
	logic [3:0]       wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic             do_wr;
	logic             wr_acs;
	logic             wr_ist;

	// ==========================================
	// receiver state
	uep_state_t       state;
	logic             rx_m;
	logic             rx_s;
	logic [3:0]       cnt;
	logic [2:0]       bitn;
	logic [7:0]       shift;
	logic             par_bit;
	logic             xfer;
	logic             err_evt;
	logic             stop_done;
	logic [7:0]       frame_data;
	logic             par_exp;
	logic             par_bad;
	logic             rd_rxd;

	// handshake outputs
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_bresp   = RESP_OKAY;

	// write decode
	assign do_wr  = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_acs = do_wr && wr_addr == ADDR_ACS && wr_strb[0];
	assign wr_ist = do_wr && wr_addr == ADDR_IST && wr_strb[0];
	assign rd_rxd = s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[3:0] == ADDR_RXD;

	// pin function follows receiver enable
	assign receiver_pin_select = receiver_enable_bit;

	// ==========================================
	// write address and data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			wr_addr <= 4'h0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				wr_addr <= s_axi_awaddr[3:0];
			end else if (do_wr) begin
				aw_hold <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (do_wr) begin
				w_hold <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// read channel, registered data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr[3:0])
				ADDR_ACS: s_axi_rdata <= {24'h00_0000, rx_error_flag,
					software_semaphore_bit, receiver_enable_bit,
					parity_sense_select, acs_low};
				ADDR_RXD: s_axi_rdata <= {24'h00_0000, rx_data};
				ADDR_IST: s_axi_rdata <= {30'h0000_0000, irq_status};
				ADDR_IMK: s_axi_rdata <= {30'h0000_0000, irq_mask};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================
	// control bits, all zero at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			software_semaphore_bit <= ACS_RESET[BIT_SEM];
			receiver_enable_bit    <= ACS_RESET[BIT_REN];
			parity_sense_select    <= ACS_RESET[BIT_EVEN];
			acs_low                <= ACS_RESET[3:0];
		end else if (wr_acs) begin
			software_semaphore_bit <= wr_data[BIT_SEM];
			receiver_enable_bit    <= wr_data[BIT_REN];
			parity_sense_select    <= wr_data[BIT_EVEN];
			acs_low                <= wr_data[3:0];
		end
	end

	// error flag, set wins over write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_error_flag <= ACS_RESET[BIT_ERR];
		end else if (err_evt) begin
			rx_error_flag <= 1'b1;
		end else if (wr_acs && wr_data[BIT_ERR]) begin
			rx_error_flag <= 1'b0;
		end
	end

	// interrupt mask register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= IRQ_RESET;
		end else if (do_wr && wr_addr == ADDR_IMK && wr_strb[0]) begin
			irq_mask <= wr_data[1:0];
		end
	end

	// ==========================================
	// sticky interrupt status, set wins
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ist
			logic ev;
			assign ev = (gi == IRQ_RX) ? xfer : err_evt;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					irq_status[gi] <= 1'b0;
				end else if (ev) begin
					irq_status[gi] <= 1'b1;
				end else if (wr_ist && wr_data[gi]) begin
					irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// level interrupt from unmasked status
	assign irq = |(irq_status & irq_mask);

	// receive interrupt pulse per transfer
	assign receive_interrupt_request = xfer;

	// ==========================================
	// receive pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_m <= 1'b1;
			rx_s <= 1'b1;
		end else begin
			rx_m <= serial_receive_pin;
			rx_s <= rx_m;
		end
	end

	// frame data and parity check
	assign frame_data = acs_low[BIT_W8] ? shift : {1'b0, shift[7:1]};
	assign par_exp = (^frame_data) ^ ~parity_sense_select;
	assign par_bad = acs_low[BIT_PEN] && (par_bit != par_exp);
	assign stop_done = state == UEP_STOP && baud_tick16
		&& cnt == TICK_LAST;

	// ==========================================
	// receiver state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= UEP_IDLE;
			cnt     <= 4'h0;
			bitn    <= 3'h0;
			shift   <= 8'h00;
			par_bit <= 1'b0;
			rx_data <= 8'h00;
			xfer    <= 1'b0;
			err_evt <= 1'b0;
		end else begin
			xfer    <= 1'b0;
			err_evt <= 1'b0;
			if (!receiver_enable_bit) begin
				state <= UEP_IDLE;
			end else begin
				case (state)
					UEP_IDLE: begin
						cnt <= 4'h0;
						if (!rx_s) begin
							state <= UEP_START;
						end
					end
					UEP_START: begin
						if (baud_tick16) begin
							cnt <= cnt + 4'h1;
							if (cnt == TICK_HALF) begin
								cnt  <= 4'h0;
								bitn <= 3'h0;
								state <= rx_s ? UEP_IDLE : UEP_DATA;
							end
						end
					end
					UEP_DATA: begin
						if (baud_tick16) begin
							cnt <= cnt + 4'h1;
							if (cnt == TICK_LAST) begin
								shift <= {rx_s, shift[7:1]};
								bitn  <= bitn + 3'h1;
								if (bitn == (acs_low[BIT_W8] ? BITS_W8 : BITS_W7)) begin
									state <= acs_low[BIT_PEN] ? UEP_PAR : UEP_STOP;
								end
							end
						end
					end
					UEP_PAR: begin
						if (baud_tick16) begin
							cnt <= cnt + 4'h1;
							if (cnt == TICK_LAST) begin
								par_bit <= rx_s;
								state   <= UEP_STOP;
							end
						end
					end
					UEP_STOP: begin
						if (baud_tick16) begin
							cnt <= cnt + 4'h1;
						end
						if (stop_done) begin
							rx_data <= frame_data;
							xfer    <= 1'b1;
							// frame, parity and overrun faults
							err_evt <= !rx_s || par_bad || unread;
							state   <= UEP_IDLE;
						end
					end
					default: state <= UEP_IDLE;
				endcase
			end
		end
	end

	// unread marker, new data wins over read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unread <= 1'b0;
		end else if (xfer) begin
			unread <= 1'b1;
		end else if (rd_rxd) begin
			unread <= 1'b0;
		end
	end

	// ==========================================
	// assertions
	property p_err_set;
		@(posedge aclk) disable iff (!aresetn)
		err_evt |=> rx_error_flag;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error flag not set");

	property p_frame;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && receiver_enable_bit && !rx_s) |=> err_evt ##1 rx_error_flag;
	endproperty
	a_frame: assert property (p_frame) else $error("framing fault missed");

	property p_parity;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && receiver_enable_bit && acs_low[BIT_PEN] && par_bit != par_exp) |=> err_evt;
	endproperty
	a_parity: assert property (p_parity) else $error("parity fault missed");

	property p_overrun;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && receiver_enable_bit && unread) |=> err_evt;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_even;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && receiver_enable_bit && acs_low[BIT_PEN] && parity_sense_select
			&& (^{frame_data, par_bit})) |=> err_evt;
	endproperty
	a_even: assert property (p_even) else $error("even parity odd count accepted");

	property p_odd;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && receiver_enable_bit && acs_low[BIT_PEN] && !parity_sense_select
			&& !(^{frame_data, par_bit})) |=> err_evt;
	endproperty
	a_odd: assert property (p_odd) else $error("odd parity even count accepted");

	property p_w0_keep;
		@(posedge aclk) disable iff (!aresetn)
		(rx_error_flag && !(wr_acs && wr_data[BIT_ERR])) |=> rx_error_flag;
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("error flag lost");

	property p_w1_clr;
		@(posedge aclk) disable iff (!aresetn)
		(wr_acs && wr_data[BIT_ERR] && !err_evt) |=> !rx_error_flag;
	endproperty
	a_w1_clr: assert property (p_w1_clr) else $error("error flag not cleared");

	property p_disable;
		@(posedge aclk) disable iff (!aresetn)
		!receiver_enable_bit |=> state == UEP_IDLE && !xfer && !receive_interrupt_request;
	endproperty
	a_disable: assert property (p_disable) else $error("receiver active while disabled");

	property p_sem;
		@(posedge aclk) disable iff (!aresetn)
		!$stable(software_semaphore_bit) |-> $past(wr_acs);
	endproperty
	a_sem: assert property (p_sem) else $error("semaphore changed without write");

	property p_reset;
		@(posedge aclk)
		!aresetn |=> !rx_error_flag && !software_semaphore_bit && !receiver_enable_bit
			&& !parity_sense_select && acs_low == 4'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("register not zero after reset");

	property p_rxint;
		@(posedge aclk) disable iff (!aresetn)
		(stop_done && receiver_enable_bit) |=> receive_interrupt_request ##1 irq_status[IRQ_RX];
	endproperty
	a_rxint: assert property (p_rxint) else $error("receive interrupt missing");

endmodule // uep_rx_ctrl

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// ==========================================
// register-level bench for the receive control block
module testbench;
	import uep_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, tick, pin, pin_sel, rx_req, irq;
	logic [31:0] awaddr, wdata, araddr, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rr;
	logic [7:0]  cv;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          n_pulse = 0;

	// clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	uep_rx_ctrl dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.baud_tick16(tick), .serial_receive_pin(pin), .receiver_pin_select(pin_sel),
		.receive_interrupt_request(rx_req), .irq(irq));
	uep_serial_tx tx (.aclk(aclk), .baud_tick16(tick), .serial_receive_pin(pin));

	// count receive pulses
	always @(posedge aclk) if (rx_req === 1'b1) n_pulse <= n_pulse + 1;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// axi4-lite write, each channel released when taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// handshakes judged on settled values just before the edge
		do begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid === 1'b1 && bready;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end while (!b_t);
		bready <= 1'b0;
	endtask

	// axi4-lite read
	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// data taken while it stands, before the edge that ends it
		do begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid === 1'b1 && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
		end while (!r_t);
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		rd_reg(a, rd, rr);
		chk(rd, exp);
	endtask

	// clear flag and status, drop unread data
	task automatic clr;
		wr({28'h0, ADDR_ACS}, {24'h0, cv | 8'h80});
		wr({28'h0, ADDR_IST}, 32'h3);
		rd_reg({28'h0, ADDR_RXD}, rd, rr);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		tally_and_finish;
	end

	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		wstrb = 4'hF;
		cv = 8'h00;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk({28'h0, ADDR_ACS}, 32'h0);
		chk({31'h0, pin_sel}, 32'h0);
		wr({28'h0, ADDR_ACS}, 32'h40);
		rd_chk({28'h0, ADDR_ACS}, 32'h40);
		wr({28'h0, ADDR_IMK}, 32'h3);
		$display("test reset and semaphore done");
		// even and odd parity, good and bad, semaphore set throughout
		for (int m = 0; m < 4; m++) begin
			cv = {3'b011, m[1], 4'hC};
			wr({28'h0, ADDR_ACS}, {24'h0, cv});
			chk({31'h0, pin_sel}, 32'h1);
			tx.send(8'h3C + m, m[1], m[0], 1'b0);
			chk({31'h0, irq}, 32'h1);
			rd_chk({28'h0, ADDR_RXD}, 8'h3C + m);
			rd_chk({28'h0, ADDR_ACS}, {m[0], cv[6:0]});
			clr;
			chk({31'h0, irq}, 32'h0);
		end
		chk(n_pulse, 4);
		$display("test parity done");
		// framing fault, flag survives a zero write, masking
		tx.send(8'h55, cv[4], 1'b0, 1'b1);
		rd_chk({28'h0, ADDR_ACS}, {1'b1, cv[6:0]});
		wr({28'h0, ADDR_ACS}, {24'h0, cv});
		rd_chk({28'h0, ADDR_ACS}, {1'b1, cv[6:0]});
		wr({28'h0, ADDR_IMK}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr({28'h0, ADDR_IMK}, 32'h2);
		chk({31'h0, irq}, 32'h1);
		clr;
		rd_chk({28'h0, ADDR_ACS}, {24'h0, cv});
		$display("test framing done");
		// overrun: second character before the first is read
		tx.send(8'h11, cv[4], 1'b0, 1'b0);
		rd_chk({28'h0, ADDR_ACS}, {24'h0, cv});
		tx.send(8'h22, cv[4], 1'b0, 1'b0);
		rd_chk({28'h0, ADDR_RXD}, 32'h22);
		rd_chk({28'h0, ADDR_ACS}, {1'b1, cv[6:0]});
		clr;
		$display("test overrun done");
		// receiver disabled: no character, no pulse
		cv = 8'h1C;
		wr({28'h0, ADDR_ACS}, {24'h0, cv});
		chk({31'h0, pin_sel}, 32'h0);
		tx.send(8'h77, 1'b1, 1'b0, 1'b0);
		chk(n_pulse, 7);
		rd_chk({28'h0, ADDR_IST}, 32'h0);
		rd_reg(32'h2, rd, rr);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		$display("test disable done");
		tally_and_finish;
	end
endmodule // testbench

// *** tb/uep_serial_tx.sv ***
`timescale 1ns/1ps
// ==========================================
// remote serial transmitter and 16x tick source
module uep_serial_tx (
	// clock
	input  wire logic aclk,
	// serial side
	output wire logic baud_tick16,
	output wire logic serial_receive_pin
);
	localparam int BIT_CYC = 32;
	logic tick = 1'b0;
	logic line = 1'b1;
	assign baud_tick16 = tick;
	assign serial_receive_pin = line;

	// tick every other cycle, so one bit is 32 cycles
	always @(posedge aclk) tick <= ~tick;

	// start, 8 data lsb first, parity, stop; line idles high
	task automatic send(input logic [7:0] d, input logic even, input logic bad_par, input logic bad_stop);
		logic [10:0] f;
		f = {~bad_stop, (^d) ^ ~even ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge aclk);
			line <= f[i];
			repeat ((i == 10 && bad_stop) ? 23 : BIT_CYC - 1) @(posedge aclk);
		end
		// short low stop avoids a false start after the bad frame
		@(posedge aclk);
		line <= 1'b1;
		repeat (24) @(posedge aclk);
	endtask
endmodule // uep_serial_tx
